// ==== rtl/esc_pkg.sv ====
// constants shared by the error statistics counter block
// assumes one system clock; register port with one-cycle read data
// Notes on behaviour
// - late collision counted after 512 bit times
// - counters hold at all ones
// - any counter write clears it, data ignored
// - upper sixteen bits read as zero
// - count sits in low sixteen bits
// - carrier drop during data transmission counted
// - carrier absent during preamble counted
// - transmit attempt under four bytes counted
// - received bad frame check counted
// - bad check not counted when accepted
// - receive error activation during frame counted
`default_nettype none
package esc_pkg;
    localparam int CNT_W = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int LEN_W = 12;
    localparam int NUM_CNT = 6;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
    localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
    localparam logic [9:0] LATE_COL_BITS = 10'h200;
    localparam logic [LEN_W-1:0] MIN_TX_LEN = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_LATE_COL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_LOST_CAR = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_NO_CAR = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_ILL_LEN = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_CRC_ERR = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_RX_ERR = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_MODE = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h20;
    localparam int MODE_ACCEPT_BAD_CRC_BIT = 0;
    localparam logic [NUM_CNT-1:0] IRQ_RESET = 6'h00;
    localparam int EV_LATE_COL = 0;
    localparam int EV_LOST_CAR = 1;
    localparam int EV_NO_CAR = 2;
    localparam int EV_ILL_LEN = 3;
    localparam int EV_CRC_ERR = 4;
    localparam int EV_RX_ERR = 5;
    typedef enum logic [1:0] {
        LC_IDLE = 2'b00,
        LC_EARLY = 2'b01,
        LC_LATE = 2'b11
    } esc_lc_state_t;
endpackage : esc_pkg
`default_nettype wire

// ==== rtl/esc_pin_sync.sv ====
// two-flop synchroniser for a pin, with edge pulses
// assumes pin is asynchronous to sys_clk
`default_nettype none
module esc_pin_sync
    import esc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic pin_in,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;
    // first flop feeds only the second
    always_ff @(posedge sys_clk)
    begin
        meta_ff <= rst ? 1'b0 : pin_in;
        sync_ff <= rst ? 1'b0 : meta_ff;
        prev_ff <= rst ? 1'b0 : sync_ff;
    end
    assign level = sync_ff;
    assign rise = sync_ff & ~prev_ff;
    assign fall = ~sync_ff & prev_ff;
endmodule : esc_pin_sync
`default_nettype wire

// ==== rtl/esc_sat_counter.sv ====
// one saturating statistics counter with clear
// assumes inc and clr are single-cycle, same clock
`default_nettype none
module esc_sat_counter
    import esc_pkg::*;
#(
    parameter int WIDTH = CNT_W
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic inc,
    input wire logic clr,
    output logic [WIDTH-1:0] count_ff
);
    logic [WIDTH-1:0] nxt_count;
    wire at_max = &count_ff;
    // clear wins so software never sees a stale partial count
    assign nxt_count = clr ? '0 :
        ((inc && !at_max) ? count_ff + 1'b1 : count_ff);
    always_ff @(posedge sys_clk)
    begin
        count_ff <= rst ? WIDTH'(CNT_RESET) : nxt_count;
    end
    a_sat_hold: assert property (@(posedge sys_clk) disable iff (rst)
        at_max && !clr |=> &count_ff)
        else $error("counter left saturation without clear");
    a_clr_zero: assert property (@(posedge sys_clk) disable iff (rst)
        clr |=> count_ff == '0)
        else $error("counter not zero after clear");
    a_inc_step: assert property (@(posedge sys_clk) disable iff (rst)
        inc && !clr && !at_max |=> count_ff == $past(count_ff) + 1'b1)
        else $error("counter failed to step");
endmodule : esc_sat_counter
`default_nettype wire

// ==== rtl/esc_stat_top.sv ====
// error statistics counters of the mac, with register port and irq
// assumes tx/rx engine inputs are on sys_clk; phy pins are asynchronous
//
// The implementer's own choices: the plain strobed port and the register offsets.
`default_nettype none
module esc_stat_top
    import esc_pkg::*;
#(
    parameter int LEN_WIDTH = LEN_W
)
(
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    output logic irq,
    // transmit engine
    input wire logic tx_start,
    input wire logic tx_active,
    input wire logic tx_preamble,
    input wire logic tx_bit_tick,
    input wire logic tx_attempt,
    input wire logic [LEN_WIDTH-1:0] tx_frame_len,
    // receive engine
    input wire logic rx_frame_end,
    input wire logic rx_crc_bad,
    // phy pins
    input wire logic phy_col,
    input wire logic phy_crs,
    input wire logic phy_rx_dv,
    input wire logic phy_rx_er
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // synchronised phy pins
    logic col_lvl;
    logic col_rise;
    logic crs_lvl;
    logic crs_rise;
    logic crs_fall;
    logic rxdv_lvl;
    logic rxer_rise;

    esc_pin_sync u_sync_col (
        .sys_clk(sys_clk),
        .rst(rst),
        .pin_in(phy_col),
        .level(col_lvl),
        .rise(col_rise),
        .fall()
    );

    esc_pin_sync u_sync_crs (
        .sys_clk(sys_clk),
        .rst(rst),
        .pin_in(phy_crs),
        .level(crs_lvl),
        .rise(crs_rise),
        .fall(crs_fall)
    );

    esc_pin_sync u_sync_rxdv (
        .sys_clk(sys_clk),
        .rst(rst),
        .pin_in(phy_rx_dv),
        .level(rxdv_lvl),
        .rise(),
        .fall()
    );

    esc_pin_sync u_sync_rxer (
        .sys_clk(sys_clk),
        .rst(rst),
        .pin_in(phy_rx_er),
        .level(),
        .rise(rxer_rise),
        .fall()
    );

    // late collision window: bit times since start of data
    esc_lc_state_t lc_state_ff;
    esc_lc_state_t nxt_lc_state;
    logic [9:0] bit_cnt_ff;
    logic [9:0] nxt_bit_cnt;
    wire bit_last = (bit_cnt_ff == LATE_COL_BITS - 10'h001);

    always_comb
    begin
        nxt_lc_state = lc_state_ff;
        nxt_bit_cnt = bit_cnt_ff;
        case (lc_state_ff)
            LC_IDLE:
            begin
                nxt_bit_cnt = 10'h000;
                if (tx_start)
                    nxt_lc_state = LC_EARLY;
            end
            LC_EARLY:
            begin
                if (!tx_active)
                    nxt_lc_state = LC_IDLE;
                else if (tx_bit_tick && bit_last)
                    nxt_lc_state = LC_LATE;
                else if (tx_bit_tick)
                    nxt_bit_cnt = bit_cnt_ff + 10'h001;
            end
            LC_LATE:
            begin
                if (!tx_active)
                    nxt_lc_state = LC_IDLE;
            end
            default:
                nxt_lc_state = LC_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        lc_state_ff <= rst ? LC_IDLE : nxt_lc_state;
        bit_cnt_ff <= rst ? 10'h000 : nxt_bit_cnt;
    end

    // collisions inside the first 512 bits are normal, not counted
    wire ev_late_col = col_rise && (lc_state_ff == LC_LATE);

    // data phase is transmit minus preamble
    wire tx_data = tx_active && !tx_preamble;
    wire ev_lost_car = crs_fall && tx_data;

    // carrier seen at any time during one preamble
    logic pre_seen_ff;
    logic pre_prev_ff;
    logic nxt_pre_seen;
    assign nxt_pre_seen = tx_preamble ? (pre_seen_ff | crs_lvl) : 1'b0;
    always_ff @(posedge sys_clk)
    begin
        pre_seen_ff <= rst ? 1'b0 : nxt_pre_seen;
        pre_prev_ff <= rst ? 1'b0 : tx_preamble;
    end
    // judged once at the end of each preamble
    wire pre_end = pre_prev_ff && !tx_preamble;
    wire ev_no_car = pre_end && !pre_seen_ff;

    wire ev_ill_len = tx_attempt && (tx_frame_len < MIN_TX_LEN);

    // mode register
    logic accept_bad_crc_frames_ff;
    wire ev_crc_err = rx_frame_end && rx_crc_bad
        && !accept_bad_crc_frames_ff;

    // rx error only counts inside a frame
    wire ev_rx_err = rxer_rise && rxdv_lvl;

    // register decode
    wire hit_late = (reg_addr == OFS_LATE_COL);
    wire hit_lost = (reg_addr == OFS_LOST_CAR);
    wire hit_nocar = (reg_addr == OFS_NO_CAR);
    wire hit_ill = (reg_addr == OFS_ILL_LEN);
    wire hit_crc = (reg_addr == OFS_CRC_ERR);
    wire hit_rxer = (reg_addr == OFS_RX_ERR);
    wire hit_mode = (reg_addr == OFS_MODE);
    wire hit_stat = (reg_addr == OFS_IRQ_STAT);
    wire hit_mask = (reg_addr == OFS_IRQ_MASK);

    wire [NUM_CNT-1:0] cnt_hit = {hit_rxer, hit_crc, hit_ill,
        hit_nocar, hit_lost, hit_late};
    // write data ignored; any write clears the addressed counter
    wire [NUM_CNT-1:0] cnt_clr = cnt_hit & {NUM_CNT{reg_wr}};
    wire [NUM_CNT-1:0] ev_vec = {ev_rx_err, ev_crc_err, ev_ill_len,
        ev_no_car, ev_lost_car, ev_late_col};

    logic [CNT_W-1:0] cnt_val [NUM_CNT];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CNT; gi++)
        begin : g_cnt
            esc_sat_counter #(
                .WIDTH(CNT_W)
            ) u_cnt (
                .sys_clk(sys_clk),
                .rst(rst),
                .inc(ev_vec[gi]),
                .clr(cnt_clr[gi]),
                .count_ff(cnt_val[gi])
            );
        end
    endgenerate

    wire [CNT_W-1:0] late_collision_value = cnt_val[EV_LATE_COL];
    wire [CNT_W-1:0] lost_carrier_value = cnt_val[EV_LOST_CAR];
    wire [CNT_W-1:0] no_carrier_value = cnt_val[EV_NO_CAR];
    wire [CNT_W-1:0] illegal_length_value = cnt_val[EV_ILL_LEN];
    wire [CNT_W-1:0] crc_error_value = cnt_val[EV_CRC_ERR];
    wire [CNT_W-1:0] rx_error_value = cnt_val[EV_RX_ERR];

    // mode register write; only the accept bit is implemented
    wire mode_wr = reg_wr && hit_mode;
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            accept_bad_crc_frames_ff <= 1'b0;
        else if (mode_wr)
            accept_bad_crc_frames_ff <=
                reg_wdata[MODE_ACCEPT_BAD_CRC_BIT];
    end

    // interrupt status: set beats read-clear
    logic [NUM_CNT-1:0] irq_stat_ff;
    logic [NUM_CNT-1:0] irq_mask_ff;
    logic [NUM_CNT-1:0] nxt_irq_stat;
    wire stat_rd = reg_rd && hit_stat;
    assign nxt_irq_stat = (stat_rd ? {NUM_CNT{1'b0}} : irq_stat_ff)
        | ev_vec;
    always_ff @(posedge sys_clk)
    begin
        irq_stat_ff <= rst ? IRQ_RESET : nxt_irq_stat;
    end
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            irq_mask_ff <= IRQ_RESET;
        else if (reg_wr && hit_mask)
            irq_mask_ff <= reg_wdata[NUM_CNT-1:0];
    end
    assign irq = |(irq_stat_ff & irq_mask_ff);

    // read mux; counters zero-extended so reserved bits read zero
    logic [DATA_W-1:0] rd_mux;
    always_comb
    begin
        if (hit_late)
            rd_mux = {16'h0000, late_collision_value};
        else if (hit_lost)
            rd_mux = {16'h0000, lost_carrier_value};
        else if (hit_nocar)
            rd_mux = {16'h0000, no_carrier_value};
        else if (hit_ill)
            rd_mux = {16'h0000, illegal_length_value};
        else if (hit_crc)
            rd_mux = {16'h0000, crc_error_value};
        else if (hit_rxer)
            rd_mux = {16'h0000, rx_error_value};
        else if (hit_mode)
            rd_mux = {31'h00000000, accept_bad_crc_frames_ff};
        else if (hit_stat)
            rd_mux = {26'h0000000, irq_stat_ff};
        else if (hit_mask)
            rd_mux = {26'h0000000, irq_mask_ff};
        else
            rd_mux = 32'h00000000;
    end

    // read data valid only in the cycle after the strobe
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] nxt_rdata;
    assign nxt_rdata = reg_rd ? rd_mux : 32'h00000000;
    always_ff @(posedge sys_clk)
    begin
        rdata_ff <= rst ? 32'h00000000 : nxt_rdata;
    end
    assign reg_rdata = rdata_ff;

    // checks
    sequence s_col_late;
        col_rise && lc_state_ff == LC_LATE;
    endsequence

    sequence s_col_early;
        col_rise && lc_state_ff != LC_LATE;
    endsequence

    a_late_count: assert property (
        s_col_late and (!cnt_clr[EV_LATE_COL]
        && late_collision_value != CNT_MAX)
        |=> late_collision_value == $past(late_collision_value) + 16'h0001)
        else $error("late collision not counted");

    a_early_ignored: assert property (
        s_col_early |=> late_collision_value
        == $past(late_collision_value) || $past(cnt_clr[EV_LATE_COL]))
        else $error("early collision counted");

    a_upper_zero: assert property (
        reg_rd && (cnt_hit != '0) |=> reg_rdata[31:16] == 16'h0000)
        else $error("reserved counter bits not zero");

    a_read_value: assert property (
        reg_rd && hit_crc && !ev_crc_err && !reg_wr
        |=> reg_rdata[15:0] == crc_error_value)
        else $error("counter read value wrong");

    a_lost_carrier: assert property (
        crs_fall && tx_data && !cnt_clr[EV_LOST_CAR]
        && lost_carrier_value != CNT_MAX
        |=> lost_carrier_value != $past(lost_carrier_value))
        else $error("lost carrier not counted");

    a_no_carrier: assert property (
        tx_preamble && crs_lvl ##1 !tx_preamble
        |=> $stable(no_carrier_value) || $past(cnt_clr[EV_NO_CAR], 1))
        else $error("no-carrier counted with carrier present");

    a_ill_len: assert property (
        tx_attempt && tx_frame_len >= MIN_TX_LEN && !cnt_clr[EV_ILL_LEN]
        |=> $stable(illegal_length_value))
        else $error("legal length counted as illegal");

    a_crc_count: assert property (
        rx_frame_end && rx_crc_bad && !accept_bad_crc_frames_ff
        && !cnt_clr[EV_CRC_ERR] && crc_error_value != CNT_MAX
        |=> crc_error_value == $past(crc_error_value) + 16'h0001)
        else $error("crc error frame not counted");

    a_no_car_count: assert property (
        pre_end && !pre_seen_ff && !cnt_clr[EV_NO_CAR]
        && no_carrier_value != CNT_MAX
        |=> no_carrier_value == $past(no_carrier_value) + 16'h0001)
        else $error("missing carrier not counted");

    // status must catch every rx error event, even a saturated one
    a_stat_set: assert property (
        ev_vec[EV_RX_ERR] |=> irq_stat_ff[EV_RX_ERR])
        else $error("status bit not set by event");

    a_crc_accept: assert property (
        accept_bad_crc_frames_ff && !cnt_clr[EV_CRC_ERR]
        |=> crc_error_value == $past(crc_error_value))
        else $error("crc error counted while accepted");

    a_rx_err: assert property (
        rxer_rise && rxdv_lvl && !cnt_clr[EV_RX_ERR]
        && rx_error_value != CNT_MAX
        |=> rx_error_value == $past(rx_error_value) + 16'h0001)
        else $error("receive error not counted");

    a_clr_wins: assert property (
        reg_wr && hit_rxer && ev_rx_err |=> rx_error_value == 16'h0000)
        else $error("clear lost to increment");

    a_rdata_once: assert property (
        !reg_rd |=> reg_rdata == 32'h00000000)
        else $error("read data outside read cycle");

    a_irq_sticky: assert property (
        ev_vec[EV_CRC_ERR] |=> irq_stat_ff[EV_CRC_ERR] [*2] or
        (irq_stat_ff[EV_CRC_ERR] ##1 $past(stat_rd)))
        else $error("status bit not held");
endmodule : esc_stat_top
`default_nettype wire

// ==== tb/esc_phy_model.sv ====
// behavioural phy: collision, carrier and receive pins
// assumes the bench calls its tasks; pins change after sys_clk edges
`default_nettype none
module esc_phy_model
(
    input wire logic sys_clk,
    output logic col,
    output logic crs,
    output logic rx_dv,
    output logic rx_er
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        col = 1'b0;
        crs = 1'b0;
        rx_dv = 1'b0;
        rx_er = 1'b0;
    end
    // rx_er only asserted inside a frame, as a real phy would
    task automatic rx_error_frame();
        @(posedge sys_clk) rx_dv <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rx_er <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rx_er <= 1'b0;
        rx_dv <= 1'b0;
    endtask : rx_error_frame
    // pulse long enough to pass the two-flop synchroniser
    task automatic collide();
        @(posedge sys_clk) col <= 1'b1;
        repeat (4) @(posedge sys_clk);
        col <= 1'b0;
    endtask : collide
    task automatic carrier(logic on);
        @(posedge sys_clk) crs <= on;
    endtask : carrier
endmodule : esc_phy_model
`default_nettype wire

// ==== tb/esc_stat_top_bench.sv ====
// self-checking bench for the error statistics counters
// assumes esc_pkg and the rtl files are compiled first
`default_nettype none
module esc_stat_top_bench;
    import esc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic irq;
    logic tx_start = 1'b0;
    logic tx_active = 1'b0;
    logic tx_preamble = 1'b0;
    logic tx_bit_tick = 1'b0;
    logic tx_attempt = 1'b0;
    logic [LEN_W-1:0] tx_frame_len = '0;
    logic rx_frame_end = 1'b0;
    logic rx_crc_bad = 1'b0;
    wire logic phy_col;
    wire logic phy_crs;
    wire logic phy_rx_dv;
    wire logic phy_rx_er;
    int err_total = 0;
    int num_checks = 0;
    int cycles = 0;
    always #2 sys_clk = ~sys_clk;
    esc_stat_top #(.LEN_WIDTH(LEN_W)) DUT (.sys_clk(sys_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .tx_start(tx_start), .tx_active(tx_active),
        .tx_preamble(tx_preamble), .tx_bit_tick(tx_bit_tick),
        .tx_attempt(tx_attempt), .tx_frame_len(tx_frame_len),
        .rx_frame_end(rx_frame_end), .rx_crc_bad(rx_crc_bad),
        .phy_col(phy_col), .phy_crs(phy_crs), .phy_rx_dv(phy_rx_dv),
        .phy_rx_er(phy_rx_er));
    esc_phy_model phy (.sys_clk(sys_clk), .col(phy_col), .crs(phy_crs),
        .rx_dv(phy_rx_dv), .rx_er(phy_rx_er));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run
    // ceiling covers the saturation run plus margin
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 70000)
        begin
            err_total = err_total + 1;
            complete_run();
        end
    end
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        num_checks = num_checks + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    // data stands only in the cycle after the strobe
    task automatic rdc(logic [7:0] a, logic [31:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rdc
    task automatic t_reset();
        for (int i = 0; i < NUM_CNT; i++)
            rdc(8'(i * 4), 32'h0);
        rdc(8'h40, 32'h0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_rx_err_irq();
        phy.rx_error_frame();
        tick(6);
        chk({31'h0, irq}, 32'h0);
        rdc(OFS_IRQ_STAT, 32'h20);
        wr(OFS_IRQ_MASK, 32'h20);
        phy.rx_error_frame();
        tick(6);
        chk({31'h0, irq}, 32'h1);
        rdc(OFS_IRQ_STAT, 32'h20);
        chk({31'h0, irq}, 32'h0);
        rdc(OFS_RX_ERR, 32'h2);
        // clear strobe lands on the edge that sees the error rise
        fork
            phy.rx_error_frame();
            begin
                tick(4);
                wr(OFS_RX_ERR, 32'h0);
            end
        join
        rdc(OFS_RX_ERR, 32'h0);
        $display("test rx error and irq done");
    endtask : t_rx_err_irq
    task automatic t_crc();
        @(posedge sys_clk) rx_frame_end <= 1'b1;
        rx_crc_bad <= 1'b1;
        @(posedge sys_clk) rx_crc_bad <= 1'b0;
        @(posedge sys_clk) rx_frame_end <= 1'b0;
        rdc(OFS_CRC_ERR, 32'h1);
        wr(OFS_MODE, 32'h1);
        @(posedge sys_clk) rx_frame_end <= 1'b1;
        rx_crc_bad <= 1'b1;
        @(posedge sys_clk) rx_frame_end <= 1'b0;
        rx_crc_bad <= 1'b0;
        rdc(OFS_CRC_ERR, 32'h1);
        wr(OFS_MODE, 32'h0);
        $display("test crc done");
    endtask : t_crc
    task automatic t_ill_len();
        for (int n = 3; n <= 4; n++)
        begin
            @(posedge sys_clk) tx_attempt <= 1'b1;
            tx_frame_len <= LEN_W'(n);
            @(posedge sys_clk) tx_attempt <= 1'b0;
        end
        rdc(OFS_ILL_LEN, 32'h1);
        $display("test illegal length done");
    endtask : t_ill_len
    task automatic t_late_col();
        @(posedge sys_clk) tx_start <= 1'b1;
        tx_active <= 1'b1;
        @(posedge sys_clk) tx_start <= 1'b0;
        tx_bit_tick <= 1'b1;
        tick(511);
        tx_bit_tick <= 1'b0;
        phy.collide();
        tick(4);
        rdc(OFS_LATE_COL, 32'h0);
        @(posedge sys_clk) tx_bit_tick <= 1'b1;
        @(posedge sys_clk) tx_bit_tick <= 1'b0;
        phy.collide();
        tick(4);
        @(posedge sys_clk) tx_active <= 1'b0;
        rdc(OFS_LATE_COL, 32'h1);
        $display("test late collision done");
    endtask : t_late_col
    task automatic t_carrier();
        @(posedge sys_clk) tx_active <= 1'b1;
        tx_preamble <= 1'b1;
        tick(8);
        tx_preamble <= 1'b0;
        tick(2);
        tx_active <= 1'b0;
        rdc(OFS_NO_CAR, 32'h1);
        @(posedge sys_clk) tx_active <= 1'b1;
        tx_preamble <= 1'b1;
        phy.carrier(1'b1);
        tick(8);
        tx_preamble <= 1'b0;
        tick(4);
        phy.carrier(1'b0);
        tick(6);
        tx_active <= 1'b0;
        rdc(OFS_NO_CAR, 32'h1);
        rdc(OFS_LOST_CAR, 32'h1);
        $display("test carrier done");
    endtask : t_carrier
    // held attempt counts every cycle; slow but exercises the ceiling
    task automatic t_saturate();
        @(posedge sys_clk) tx_attempt <= 1'b1;
        tx_frame_len <= '0;
        tick(65540);
        tx_attempt <= 1'b0;
        rdc(OFS_ILL_LEN, 32'h0000ffff);
        wr(OFS_ILL_LEN, 32'h0000ffff);
        rdc(OFS_ILL_LEN, 32'h0);
        rdc(OFS_LATE_COL, 32'h1);
        $display("test saturation done");
    endtask : t_saturate
    initial
    begin
        tick(5);
        rst <= 1'b0;
        t_reset();
        t_rx_err_irq();
        t_crc();
        t_ill_len();
        t_late_col();
        t_carrier();
        t_saturate();
        complete_run();
    end
endmodule : esc_stat_top_bench
`default_nettype wire
